// ### rtl/sbir_regs.sv
// Purpose: identity, reset and conversion rate registers of a single-wire
//          sensor bus device
// Assumes: bus protocol engine presents decoded register reads and writes
// Notes:   strap pin and nack event feed from outside; reset is synchronous
//
// How it works
// [RQ1] power-up forces a full device reset sequence automatically
// [RQ2] writing one to the control reset bit starts a device reset
// [RQ3] device reset aborts operation, then normal operation restarts afresh
// [RQ4] device reset loads every register with its default
// [RQ5] device number register gives this device's bus address
// [RQ6] strap low maps to address 001, strap high to 111
// [RQ7] address field follows the strap level continuously
// [RQ8] device number register is read only, writes ignored
// [RQ9] sixteen-bit read-only maker identification at offset 01h
// [RQ10] bus error flag sets on nack, clears on reset or status read
// [RQ11] rate select is two bits, default binary 10, other bits zero
`timescale 1ns/1ps
module sbir_regs
    import sbir_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    // strap pin
    input  wire logic                      addr_strap_i,
    // register access from the bus engine
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    input  wire logic [`SBIR_ADDR_W-1:0]   reg_addr_i,
    input  wire logic [`SBIR_DATA_W-1:0]   reg_wdata_i,
    output logic      [`SBIR_DATA_W-1:0]   reg_rdata_o,
    // bus event from the engine
    input  wire logic                      bus_nack_i,
    // device state
    output logic                           dev_reset_o,
    output logic                           dev_run_o,
    output logic      [2:0]                dev_addr_field_o,
    output logic      [1:0]                rate_sel_o
);
    typedef struct packed {
        sbir_state_t              state;
        logic [3:0]               cnt;
        logic                     bus_error_flag;
        logic                     ctrl_reset;
        logic                     rate_sel_hi;
        logic                     rate_sel_lo;
        logic [2:0]               dev_addr_field;
        logic [`SBIR_DATA_W-1:0]  rdata;
    } sbir_regs_t;

    sbir_regs_t r_q;
    sbir_regs_t r_d;
    logic       strap_sync;

    // strap pin passes two flops before use
    sbir_sync2 u_strap_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .level_i   (addr_strap_i),
        .level_o   (strap_sync)
    );

    // next-state logic
    always_comb begin
        r_d = r_q;
        // address field tracks strap every cycle, never written by the bus
        r_d.dev_addr_field = strap_sync ? `SBIR_ADDR_HIGH : `SBIR_ADDR_LOW; // RQ5 RQ6 RQ7 RQ8
        r_d.rdata = r_q.rdata;
        unique case (r_q.state)
            SBIR_ST_POR, SBIR_ST_RESET: begin
                // hold defaults for the reset sequence, then restart
                r_d.bus_error_flag = 1'b0; // RQ4
                r_d.ctrl_reset     = 1'b0; // RQ4
                {r_d.rate_sel_hi, r_d.rate_sel_lo} = `SBIR_RATE_RESET; // RQ4 RQ11
                r_d.rdata          = '0;
                if (r_q.cnt == `SBIR_POR_CYCLES) begin
                    r_d.state = SBIR_ST_RUN; // RQ1 RQ3
                    r_d.cnt   = '0;
                end else begin
                    r_d.cnt   = r_q.cnt + 4'h1;
                end
            end
            SBIR_ST_RUN: begin
                if (reg_rd_i) begin
                    unique case (reg_addr_i)
                        `SBIR_OFS_DEVNUM:  r_d.rdata = {13'h0000, r_q.dev_addr_field}; // RQ5
                        `SBIR_OFS_MAKER:   r_d.rdata = `SBIR_MAKER_ID; // RQ9
                        `SBIR_OFS_STATUS:  r_d.rdata = {8'h00, r_q.bus_error_flag, 7'h00};
                        `SBIR_OFS_CONTROL: r_d.rdata = {15'h0000, r_q.ctrl_reset};
                        `SBIR_OFS_RATE:    r_d.rdata = {14'h0000, r_q.rate_sel_hi,
                                                        r_q.rate_sel_lo}; // RQ11
                        default:           r_d.rdata = '0;
                    endcase
                end
                // status read clears the flag, a new nack in that cycle wins
                if (reg_rd_i && reg_addr_i == `SBIR_OFS_STATUS) begin
                    r_d.bus_error_flag = 1'b0; // RQ10
                end
                if (bus_nack_i) begin
                    r_d.bus_error_flag = 1'b1; // RQ10
                end
                if (reg_wr_i && reg_addr_i == `SBIR_OFS_RATE) begin
                    r_d.rate_sel_hi = reg_wdata_i[1]; // RQ11
                    r_d.rate_sel_lo = reg_wdata_i[0]; // RQ11
                end
                if (reg_wr_i && reg_addr_i == `SBIR_OFS_CONTROL
                    && reg_wdata_i[`SBIR_CTRL_RESET]) begin
                    // bit is one only in the first cycle of the sequence, then self-clears
                    r_d.ctrl_reset = 1'b1; // RQ2
                    r_d.state      = SBIR_ST_RESET; // RQ2 RQ3
                    r_d.cnt        = '0;
                    // defaults land with the request, so no stale value shows in the sequence
                    r_d.bus_error_flag = 1'b0; // RQ4
                    {r_d.rate_sel_hi, r_d.rate_sel_lo} = `SBIR_RATE_RESET; // RQ4
                    r_d.rdata          = '0; // RQ4
                end
            end
            default: begin
                r_d.state = SBIR_ST_POR;
                r_d.cnt   = '0;
            end
        endcase
    end

    // state register; synchronous reset enters the power-up sequence
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            r_q.state          <= SBIR_ST_POR; // RQ1
            r_q.cnt            <= '0;
            r_q.bus_error_flag <= 1'b0;
            r_q.ctrl_reset     <= 1'b0;
            r_q.rate_sel_hi    <= 1'b1;
            r_q.rate_sel_lo    <= 1'b0;
            r_q.dev_addr_field <= `SBIR_ADDR_LOW;
            r_q.rdata          <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs
    assign reg_rdata_o      = r_q.rdata;
    assign dev_reset_o      = (r_q.state != SBIR_ST_RUN); // RQ3
    assign dev_run_o        = (r_q.state == SBIR_ST_RUN);
    assign dev_addr_field_o = r_q.dev_addr_field;
    assign rate_sel_o       = {r_q.rate_sel_hi, r_q.rate_sel_lo};
endmodule // sbir_regs

// ### rtl/sbir_params.svh
// Purpose: offsets, field positions, reset values and counts of the sensor bus
//          identity and reset register bank
// Assumes: six-bit register index, sixteen-bit register data
// Notes:   included by the package and the bench files
`ifndef SBIR_PARAMS_SVH
`define SBIR_PARAMS_SVH

`define SBIR_ADDR_W        6
`define SBIR_DATA_W        16
`define SBIR_OFS_DEVNUM    6'h00
`define SBIR_OFS_MAKER     6'h01
`define SBIR_OFS_STATUS    6'h04
`define SBIR_OFS_CONTROL   6'h05
`define SBIR_OFS_RATE      6'h20
`define SBIR_ADDR_LOW      3'h1
`define SBIR_ADDR_HIGH     3'h7
`define SBIR_MAKER_ID      16'h5A5A  // maker code, value is arbitrary
`define SBIR_RATE_RESET    2'h2
`define SBIR_STATUS_BER    7
`define SBIR_CTRL_RESET    0
`define SBIR_POR_CYCLES    4'h8

`endif

// ### rtl/sbir_pkg.sv
// Purpose: types of the sensor bus identity and reset register bank
// Assumes: constants come from sbir_params.svh
// Notes:   none
`include "sbir_params.svh"
package sbir_pkg;
    typedef enum logic [1:0] {
        SBIR_ST_POR   = 2'h0,
        SBIR_ST_RUN   = 2'h1,
        SBIR_ST_RESET = 2'h2
    } sbir_state_t;
endpackage

// ### rtl/sbir_sync2.sv
// Purpose: two-flop synchroniser for an outside level
// Assumes: input is asynchronous to clk_i
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module sbir_sync2 (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // level in and out
    input  wire logic level_i,
    output logic      level_o
);
    typedef struct packed {
        logic meta;
        logic sync;
    } sbir_sync_t;

    sbir_sync_t s_q;
    sbir_sync_t s_d;

    // shift the level through two stages
    always_comb begin
        s_d.meta = level_i;
        s_d.sync = s_q.meta;
    end

    // register the state
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level_o = s_q.sync;
endmodule // sbir_sync2

// ### tb/sbir_regs_monitor.sv
// Purpose: port checker of sbir_regs
// Assumes: sbir_params.svh offsets
// Notes: bound at the foot
`timescale 1ns/1ps
`include "sbir_params.svh"
module sbir_regs_monitor (
    // all ports of sbir_regs
    input wire logic clk_i, reset_n_i, addr_strap_i, reg_wr_i, reg_rd_i, bus_nack_i,
    input wire logic [`SBIR_ADDR_W-1:0] reg_addr_i,
    input wire logic [`SBIR_DATA_W-1:0] reg_wdata_i, reg_rdata_o,
    input wire logic dev_reset_o, dev_run_o,
    input wire logic [2:0] dev_addr_field_o,
    input wire logic [1:0] rate_sel_o
);
    // accepted strobes
    wire rd = reg_rd_i && dev_run_o;
    wire wr = reg_wr_i && dev_run_o;
    wire st = rd && reg_addr_i == `SBIR_OFS_STATUS && !bus_nack_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_maker_read: assert property (
        rd && reg_addr_i == `SBIR_OFS_MAKER |=> reg_rdata_o == `SBIR_MAKER_ID) else $error("id");
    a_devnum_read: assert property (
        rd && reg_addr_i == `SBIR_OFS_DEVNUM |=> reg_rdata_o inside {16'h0001, 16'h0007})
        else $error("devnum");
    a_strap_follow: assert property (
        (addr_strap_i && !dev_reset_o)[*4] |-> dev_addr_field_o == `SBIR_ADDR_HIGH)
        else $error("strap");
    a_soft_reset: assert property (
        wr && reg_addr_i == `SBIR_OFS_CONTROL && reg_wdata_i[0] |=> rate_sel_o == 2'h2
        ##0 dev_reset_o[*8] ##1 dev_reset_o && !dev_run_o ##1 dev_run_o) else $error("reset");
    a_rate_write: assert property (
        wr && reg_addr_i == `SBIR_OFS_RATE |=> rate_sel_o == $past(reg_wdata_i[1:0]))
        else $error("rate");
    a_rate_hold: assert property (
        !reg_wr_i |=> $stable(rate_sel_o)) else $error("rate hold");
    a_ber_report: assert property (
        bus_nack_i ##1 st |=> reg_rdata_o[7]) else $error("ber set");
    a_ber_clear: assert property (
        st ##1 !bus_nack_i ##1 st |=> !reg_rdata_o[7]) else $error("ber clr");
endmodule // sbir_regs_monitor
bind sbir_regs sbir_regs_monitor MON (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_strap_i(addr_strap_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .bus_nack_i(bus_nack_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .dev_reset_o(dev_reset_o), .dev_run_o(dev_run_o),
    .dev_addr_field_o(dev_addr_field_o), .rate_sel_o(rate_sel_o));

// ### tb/sbir_host_model.sv
// Purpose: bus master stand-in
// Assumes: one access at a time
// Notes: moves at the falling edge
`timescale 1ns/1ps
module sbir_host_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    output logic             wr_o, rd_o, nack_o,
    output logic [5:0]       addr_o,
    output logic [15:0]      wdata_o
);
    initial {wr_o, rd_o, nack_o, addr_o, wdata_o} = '0;
    // write; a one in control bit 0 asks for a device reset
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_i) {wr_o, addr_o, wdata_o} = {1'b1, a, d};
        @(negedge clk_i) {wr_o, wdata_o} = {1'b0, ~d};
    endtask
    // read, data taken once the answer has landed
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(negedge clk_i) {rd_o, addr_o} = {1'b1, a};
        @(negedge clk_i) rd_o = 1'b0;
        d = rdata_i;
    endtask
    // one-cycle nack event
    task automatic nack();
        @(negedge clk_i) nack_o = 1'b1;
        @(negedge clk_i) nack_o = 1'b0;
    endtask
endmodule // sbir_host_model

// ### tb/sensor_bus_identity_and_reset_bench.sv
// Purpose: self-checking bench of sbir_regs
// Assumes: host model drives accesses
// Notes: maker value is the design constant
`timescale 1ns/1ps
`include "sbir_params.svh"
`define CHK(x, y) begin num_checks++; if ((x) !== (y)) begin miscompares++; \
    $display("[FAIL] %0t got %h want %h", $time, x, y); end end
module sensor_bus_identity_and_reset_bench;
    logic        clk_i = 0, reset_n_i = 0, addr_strap_i = 0;
    logic        wr, rd, nack, dev_reset, dev_run;
    logic [5:0]  addr;
    logic [15:0] wdata, rdata, d;
    logic [2:0]  fld;
    logic [1:0]  rate;
    int          miscompares = 0, num_checks = 0, cyc = 0;
    initial forever #12.5 clk_i = ~clk_i;
    sbir_host_model HOST (.clk_i(clk_i), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
        .nack_o(nack), .addr_o(addr), .wdata_o(wdata));
    sbir_regs DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_strap_i(addr_strap_i),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .bus_nack_i(nack), .dev_reset_o(dev_reset),
        .dev_run_o(dev_run), .dev_addr_field_o(fld), .rate_sel_o(rate));
    // verdict and end of run
    task automatic wrap_up();
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin miscompares++; wrap_up(); end
    end
    task automatic rchk(input logic [5:0] a, input logic [15:0] e);
        HOST.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic wait_run();
        for (int i = 0; i < 20 && dev_run !== 1'b1; i++) @(negedge clk_i);
        `CHK(dev_run, 1'b1)
    endtask
    // main sequence
    initial begin
        repeat (12) @(negedge clk_i);
        `CHK(dev_run, 1'b0)
        reset_n_i = 1;
        wait_run();
        rchk(`SBIR_OFS_DEVNUM, 16'h0001);
        HOST.wr(`SBIR_OFS_DEVNUM, 16'hFFFF);
        rchk(`SBIR_OFS_DEVNUM, 16'h0001);
        addr_strap_i = 1;
        repeat (4) @(negedge clk_i);
        `CHK(fld, 3'h7)
        rchk(`SBIR_OFS_DEVNUM, 16'h0007);
        HOST.wr(`SBIR_OFS_MAKER, 16'h0000);
        rchk(`SBIR_OFS_MAKER, `SBIR_MAKER_ID);
        rchk(`SBIR_OFS_RATE, 16'h0002);
        HOST.wr(`SBIR_OFS_RATE, 16'hFFF1);
        rchk(`SBIR_OFS_RATE, 16'h0001);
        rchk(6'h3F, 16'h0000);
        HOST.nack();
        rchk(`SBIR_OFS_STATUS, 16'h0080);
        rchk(`SBIR_OFS_STATUS, 16'h0000);
        HOST.nack();
        HOST.wr(`SBIR_OFS_CONTROL, 16'h0001);
        `CHK(dev_reset, 1'b1)
        `CHK(rate, 2'h2)
        wait_run();
        rchk(`SBIR_OFS_STATUS, 16'h0000);
        rchk(`SBIR_OFS_RATE, 16'h0002);
        rchk(`SBIR_OFS_CONTROL, 16'h0000);
        reset_n_i = 0;
        @(negedge clk_i);
        reset_n_i = 1;
        wait_run();
        rchk(`SBIR_OFS_DEVNUM, 16'h0007);
        wrap_up();
    end
endmodule // sensor_bus_identity_and_reset_bench
